/* logic/ifsf_pkg.sv */
// Constants, state codes and field layout for the two-wire memory slave front end
package ifsf_pkg;

  // Memory geometry
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int SEL_W = 3;
  localparam int BUF_W = 21;
  localparam int BUF_DEPTH = 2;

  // Device type code; value is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h6;

  // Address byte field positions
  localparam int TYPE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam int ADDR_HI_W = 5;

  // Bit and byte counting
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] BYTE_DEV = 2'h0;
  localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
  localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;

  // Synchroniser reset: clock and data idle high
  localparam logic [5:0] SYNC_RST = 6'h30;

  // Front end states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_ACK   = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } ifsf_state_t;

endpackage

/* logic/ifsf_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ifsf_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous levels in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

/* logic/ifsf_buf.sv */
// Small valid/ready buffer between serial receive and array write
`timescale 1ns/1ps
module ifsf_buf #(
  parameter int W = 21,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] ent_q [0:DEPTH-1];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (cnt_q != (PW+1)'(DEPTH)); // Full level needs the wide count
  assign out_valid = (cnt_q != '0);
  assign out_data = ent_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Entry storage
  always_ff @(posedge clk) begin
    if (push) begin
      ent_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + PW'(push);
      rd_q <= rd_q + PW'(pop);
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

/* logic/ifsf_top.sv */
// Two-wire serial slave front end with byte array behind it
`timescale 1ns/1ps
module ifsf_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and protection
  input wire logic [2:0] device_select_pins,
  input wire logic wp_i
);

  // Wrapping address step, used by write and read paths
  function automatic logic [ifsf_pkg::ADDR_W-1:0] addr_inc(
    input logic [ifsf_pkg::ADDR_W-1:0] a
  );
    addr_inc = a + 13'h0001;
  endfunction

  logic [5:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] sel_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  ifsf_pkg::ifsf_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shreg_q;
  logic rw_q;
  logic mack_q;
  logic [ifsf_pkg::ADDR_W-1:0] addr_q;
  logic sda_oe_q;
  logic sda_o_q;

  logic rx_done;
  logic is_data;
  logic dev_match;
  logic rx_ack;
  logic push;
  logic tx_load;
  logic [7:0] rd_byte;
  logic [1:0] byte_nxt;

  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [ifsf_pkg::BUF_W-1:0] buf_out_data;
  logic [ifsf_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;

  logic [7:0] mem_q [0:ifsf_pkg::MEM_DEPTH-1];

  // Pins cross into core_clk; straps pulled low at the pad when open
  ifsf_sync #(
    .W(6),
    .RST(ifsf_pkg::SYNC_RST)
  ) u_sync (
    .clk(core_clk),
    .resetn(resetn),
    .d({scl_i, sda_i, wp_i, device_select_pins}),
    .q(sync_q)
  );

  // Synchronised levels
  assign scl_s = sync_q[5];
  assign sda_s = sync_q[4];
  assign wp_s = sync_q[3];
  assign sel_s = sync_q[2:0];

  // Previous levels for edge detection
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Clock edges and bus conditions; data moving under high clock marks them
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

  // Byte completion and address match
  assign rx_done = (state_q == ifsf_pkg::ST_RX) && scl_fall && (bit_cnt_q == ifsf_pkg::BITS_PER_BYTE);
  assign is_data = (byte_cnt_q == ifsf_pkg::BYTE_DATA);
  assign dev_match = (shreg_q[7:ifsf_pkg::TYPE_LSB] == ifsf_pkg::TYPE_CODE)
    && (shreg_q[ifsf_pkg::SEL_LSB +: ifsf_pkg::SEL_W] == sel_s);
  assign byte_nxt = is_data ? ifsf_pkg::BYTE_DATA : byte_cnt_q + 2'h1;

  // Write gate: protected data is dropped but still acknowledged
  assign push = rx_done && is_data && !wp_s && buf_in_ready;
  assign rx_ack = (byte_cnt_q == ifsf_pkg::BYTE_DEV) ? dev_match
    : (!is_data || wp_s || buf_in_ready);

  // Read load after address ack or master ack; ignores write-protect
  assign tx_load = scl_fall && (((state_q == ifsf_pkg::ST_ACK) && rw_q
    && (byte_cnt_q == ifsf_pkg::BYTE_ADDR_HI)) || ((state_q == ifsf_pkg::ST_TXACK) && mack_q));
  assign rd_byte = mem_q[addr_q];

  // Main protocol sequencer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ifsf_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 2'h0;
      shreg_q <= 8'h00;
      rw_q <= 1'h0;
      mack_q <= 1'h0;
      addr_q <= 13'h0000;
      sda_oe_q <= 1'h0;
    end else if (stop_det) begin
      // No busy phase: a start is taken on the next edge
      state_q <= ifsf_pkg::ST_IDLE;
      sda_oe_q <= 1'h0;
    end else if (start_det) begin
      // Repeated start also lands here
      state_q <= ifsf_pkg::ST_RX;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= ifsf_pkg::BYTE_DEV;
      sda_oe_q <= 1'h0;
    end else if (tx_load) begin
      state_q <= ifsf_pkg::ST_TX;
      shreg_q <= rd_byte;
      sda_oe_q <= !rd_byte[7];
      addr_q <= addr_inc(addr_q);
      bit_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        ifsf_pkg::ST_RX: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (rx_done) begin
            bit_cnt_q <= 4'h0;
            byte_cnt_q <= byte_nxt;
            if (byte_cnt_q == ifsf_pkg::BYTE_DEV) begin
              rw_q <= shreg_q[ifsf_pkg::DIR_BIT];
            end
            if (byte_cnt_q == ifsf_pkg::BYTE_ADDR_HI) begin
              addr_q[ifsf_pkg::ADDR_W-1:8] <= shreg_q[ifsf_pkg::ADDR_HI_W-1:0];
            end
            if (byte_cnt_q == ifsf_pkg::BYTE_ADDR_LO) begin
              addr_q[7:0] <= shreg_q;
            end
            if (is_data && rx_ack) begin
              addr_q <= addr_inc(addr_q);
            end
            if (rx_ack) begin
              state_q <= ifsf_pkg::ST_ACK;
              sda_oe_q <= 1'h1;
            end else begin
              state_q <= ifsf_pkg::ST_IDLE;
            end
          end
        end
        ifsf_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'h0;
            state_q <= ifsf_pkg::ST_RX;
          end
        end
        ifsf_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == ifsf_pkg::BITS_PER_BYTE) begin
              sda_oe_q <= 1'h0;
              state_q <= ifsf_pkg::ST_TXACK;
            end else begin
              shreg_q <= {shreg_q[6:0], 1'h0};
              sda_oe_q <= !shreg_q[6];
            end
          end
        end
        ifsf_pkg::ST_TXACK: begin
          if (scl_rise) begin
            mack_q <= !sda_s;
          end else if (scl_fall) begin
            state_q <= ifsf_pkg::ST_IDLE;
          end
        end
        ifsf_pkg::ST_IDLE: begin
          sda_oe_q <= 1'h0;
        end
        default: begin
          state_q <= ifsf_pkg::ST_IDLE;
          sda_oe_q <= 1'h0;
        end
      endcase
    end
  end

  // Open-drain: data level is always low, only the enable moves
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sda_o_q <= 1'h0;
    end else begin
      sda_o_q <= 1'h0;
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;

  // Received bytes wait here so an array read never loses a write
  ifsf_buf #(
    .W(ifsf_pkg::BUF_W),
    .DEPTH(ifsf_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(core_clk),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data({addr_q, shreg_q}),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // Array port is shared; a read load stalls the drain for one cycle
  assign buf_out_ready = !tx_load;
  assign wr_addr = buf_out_data[ifsf_pkg::BUF_W-1:8];
  assign wr_data = buf_out_data[7:0];

  // Byte array, not reset: contents survive like the real cells
  always_ff @(posedge core_clk) begin
    if (buf_out_valid && buf_out_ready) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Checks on the sequencer; all on core_clk and quiet during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Address byte: only our own straps get an ack
  property p_sel_match;
    $rose(state_q == ifsf_pkg::ST_ACK) && (byte_cnt_q == ifsf_pkg::BYTE_ADDR_HI)
      |-> $past(shreg_q[ifsf_pkg::SEL_LSB +: ifsf_pkg::SEL_W]) == $past(sel_s);
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("ack given to wrong select code");

  // Line is only ever pulled low
  property p_open_drain;
    sda_oe_q |-> (sda_o == 1'h0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");

  // Drive moves only after a clock fall or a bus condition
  property p_change_on_fall;
    $changed(sda_oe_q) |-> $past(scl_fall || stop_det || start_det || !scl_s);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("data changed outside clock low");

  property p_tx_steady;
    (state_q == ifsf_pkg::ST_TX) && !scl_fall && !start_det && !stop_det |=> $stable(sda_oe_q);
  endproperty
  a_tx_steady: assert property (p_tx_steady) else $error("read bit moved without clock fall");

  // Protected data never reaches the buffer; open data does whenever the buffer has room
  property p_wp_blocks;
    wp_s && rx_done && is_data |=> !buf_out_valid;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks) else $error("protected write reached buffer");

  property p_wp_low_writes;
    rx_done && is_data && !wp_s && buf_in_ready
      |=> buf_out_valid && (wr_data == $past(shreg_q)) && (wr_addr == $past(addr_q));
  endproperty
  a_wp_low_writes: assert property (p_wp_low_writes) else $error("enabled write was dropped");

  // Read load after the read header happens at either protect level
  property p_read_any_wp;
    scl_fall && (state_q == ifsf_pkg::ST_ACK) && rw_q && (byte_cnt_q == ifsf_pkg::BYTE_ADDR_HI)
      |=> (state_q == ifsf_pkg::ST_TX) && (shreg_q == $past(rd_byte));
  endproperty
  a_read_any_wp: assert property (p_read_any_wp) else $error("read byte not loaded");

  // Start and stop take effect on the next edge
  property p_start_rx;
    start_det |=> (state_q == ifsf_pkg::ST_RX) && (bit_cnt_q == 4'h0) && !sda_oe_q;
  endproperty
  a_start_rx: assert property (p_start_rx) else $error("start not taken");

  property p_stop_release;
    stop_det |=> (state_q == ifsf_pkg::ST_IDLE) && !sda_oe_q;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("stop did not release bus");

  property p_stop_write;
    stop_det && !rw_q && is_data |=> (state_q == ifsf_pkg::ST_IDLE) && !push;
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("write data taken after stop");

  // No write wait: a start straight after standby is taken
  property p_no_busy;
    (state_q == ifsf_pkg::ST_IDLE) && start_det |=> (state_q == ifsf_pkg::ST_RX);
  endproperty
  a_no_busy: assert property (p_no_busy) else $error("start refused after standby");

  // Ack stands into the ninth clock, then goes; sender lets go for it
  property p_ack_hold;
    rx_done && rx_ack |=> sda_oe_q [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not held through ninth clock");

  property p_ack_release;
    scl_fall && (state_q == ifsf_pkg::ST_ACK) && !rw_q |=> !sda_oe_q && (state_q == ifsf_pkg::ST_RX);
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock");

  property p_tx_release;
    scl_fall && (state_q == ifsf_pkg::ST_TX) && (bit_cnt_q == ifsf_pkg::BITS_PER_BYTE) |=> !sda_oe_q;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("line held in master ack slot");

  // Foreign address byte: back to standby without an ack
  property p_mismatch_idle;
    rx_done && (byte_cnt_q == ifsf_pkg::BYTE_DEV) && !dev_match
      |=> (state_q == ifsf_pkg::ST_IDLE) && !sda_oe_q;
  endproperty
  a_mismatch_idle: assert property (p_mismatch_idle) else $error("foreign address acknowledged");

  // Counter rolls over from the top location
  property p_addr_wrap;
    tx_load && (addr_q == 13'h1FFF) |=> (addr_q == 13'h0000);
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap to zero");

endmodule

/* verification/ifsf_master.sv */
// Bus master model: makes the bus clock and pulls the data line low
`timescale 1ns/1ps
module ifsf_master (
  // Clock
  input wire logic core_clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic stopping
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    stopping = 1'b0;
  end

  // Half bus period, kept well above the slave's minimum
  task automatic half();
    repeat (10) @(negedge core_clk);
  endtask

  // One bit; data moves only while the clock is low
  task automatic bit_cyc(input logic low, output logic seen);
    sda_low = low;
    half();
    scl = 1'b1;
    half();
    seen = sda;
    scl = 1'b0;
    half();
  endtask

  // Start or repeated start: data falls with the clock high
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask

  // Stop: data rises with the clock high
  task automatic stop();
    sda_low = 1'b1;
    half();
    stopping = 1'b1;
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
    stopping = 1'b0;
  endtask

  // Byte out, msb first, then released for the slave's answer
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(!b[i], s);
    bit_cyc(1'b0, s);
    ack = !s;
  endtask

  // Byte in, then our own answer: low to go on, high on the last
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b0, s);
      d[i] = s;
    end
    bit_cyc(!last, s);
  endtask
endmodule

/* verification/i2c_fram_slave_frontend_test.sv */
// Self-checking bench for the two-wire memory slave front end
`timescale 1ns/1ps
module i2c_fram_slave_frontend_test;
  logic core_clk, resetn, scl, sda_low, stopping, sda_o, sda_oe, wp_i, sda, prev_oe;
  logic [2:0] straps;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  // Open-drain wire with pull-up
  assign sda = !(sda_oe || sda_low);

  ifsf_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .stopping(stopping));
  ifsf_top dut (.core_clk(core_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .device_select_pins(straps), .wp_i(wp_i));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Line watch; stop is the one time the drive may move with the clock high
  always @(posedge core_clk) begin
    prev_oe <= sda_oe;
    cycles++;
    if (resetn && sda_oe) check("sda_o", 8'h00, {7'h0, sda_o});
    if (resetn && scl && !stopping) check("sda_oe hold", {7'h0, prev_oe}, {7'h0, sda_oe});
    if (cycles == 60000) begin
      fail_count++;
      $display("unexpected run length: expected below 60000, seen 60000");
      conclude();
    end
  end

  // Write two bytes from an address
  task automatic wr(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1);
    logic [4:0] k;
    m.start();
    m.send({ifsf_pkg::TYPE_CODE, straps, 1'b0}, k[4]);
    m.send({3'h0, a[12:8]}, k[3]);
    m.send(a[7:0], k[2]);
    m.send(d0, k[1]);
    m.send(d1, k[0]);
    m.stop();
    check("write acks", 8'h1F, {3'h0, k});
  endtask

  // Random read of one or two bytes; cut stops after the first
  task automatic rd(input logic [12:0] a, input logic cut, output logic [7:0] d0, output logic [7:0] d1);
    logic [3:0] k;
    logic s;
    m.start();
    m.send({ifsf_pkg::TYPE_CODE, straps, 1'b0}, k[3]);
    m.send({3'h0, a[12:8]}, k[2]);
    m.send(a[7:0], k[1]);
    m.start();
    m.send({ifsf_pkg::TYPE_CODE, straps, 1'b1}, k[0]);
    if (cut) begin
      // Stop in place of the ninth clock, device released, no master answer
      for (int i = 7; i >= 0; i--) begin
        m.bit_cyc(1'b0, s);
        d0[i] = s;
      end
    end else begin
      m.recv(1'b0, d0);
      m.recv(1'b1, d1);
    end
    m.stop();
    check("read acks", 8'h0F, {4'h0, k});
  endtask

  // Current-address read of one byte
  task automatic rd_cur(output logic [7:0] d);
    logic k;
    m.start();
    m.send({ifsf_pkg::TYPE_CODE, straps, 1'b1}, k);
    m.recv(1'b1, d);
    m.stop();
    check("current ack", 8'h01, {7'h0, k});
  endtask

  // Last location then wrap to zero, read back at once after stop
  task automatic t_wrap();
    logic [7:0] d0, d1;
    wr(13'h1FFF, 8'h3C, 8'hC3);
    rd(13'h1FFF, 1'b0, d0, d1);
    check("data at top", 8'h3C, d0);
    check("data at zero", 8'hC3, d1);
  endtask

  // Protected write is dropped, read still served
  task automatic t_protect();
    logic [7:0] d0, d1;
    wp_i = 1'b1;
    wr(13'h1FFF, 8'h55, 8'hAA);
    rd(13'h1FFF, 1'b0, d0, d1);
    check("protected top", 8'h3C, d0);
    check("protected zero", 8'hC3, d1);
    wp_i = 1'b0;
  endtask

  // Stop in mid read frees the line and leaves the device ready
  task automatic t_stop_read();
    logic [7:0] d0, d1;
    wr(13'h0100, 8'h81, 8'hA5);
    rd(13'h0100, 1'b1, d0, d1);
    check("cut read", 8'h81, d0);
    check("line after stop", 8'h00, {7'h0, sda_oe});
    rd_cur(d0);
    check("current read", 8'hA5, d0);
    rd(13'h0100, 1'b0, d0, d1);
    check("after cut 0", 8'h81, d0);
    check("after cut 1", 8'hA5, d1);
  endtask

  // Stop in mid data byte writes nothing more
  task automatic t_stop_write();
    logic [7:0] d0, d1;
    logic k, s;
    wr(13'h0200, 8'h11, 8'h22);
    m.start();
    m.send({ifsf_pkg::TYPE_CODE, straps, 1'b0}, k);
    m.send(8'h02, k);
    m.send(8'h01, k);
    repeat (4) m.bit_cyc(1'b0, s);
    m.stop();
    rd(13'h0200, 1'b0, d0, d1);
    check("kept 0200", 8'h11, d0);
    check("kept 0201", 8'h22, d1);
  endtask

  // Every strap value: own code answered, one foreign code ignored to the end
  task automatic t_straps();
    logic [7:0] bad;
    logic k;
    for (int s = 0; s < 8; s++) begin
      straps = s[2:0];
      m.start();
      m.send({ifsf_pkg::TYPE_CODE, straps, 1'b0}, k);
      m.stop();
      check("match ack", 8'h01, {7'h0, k});
      bad = s[0] ? {~ifsf_pkg::TYPE_CODE, straps, 1'b0} : {ifsf_pkg::TYPE_CODE, straps ^ 3'h4, 1'b0};
      m.start();
      m.send(bad, k);
      check("foreign ack", 8'h00, {7'h0, k});
      m.send(8'h00, k);
      m.stop();
      check("ignored byte", 8'h00, {7'h0, k});
    end
    straps = 3'b000;
    wr(13'h0300, 8'h5A, 8'hA5);
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    wp_i = 1'b0;
    straps = 3'b010;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    t_wrap();
    t_protect();
    t_stop_read();
    t_stop_write();
    t_straps();
    conclude();
  end
endmodule
